// file: hdl/three_level_interrupt_unit.v
// interrupt prioritisation and vectoring for sixteen sources
// assumes core_ack and core_reti are one-cycle pulses from the core,
// all inputs synchronous to clk, registers reached over apb
//
// Function
// - sixteen sources, three priority levels
// - maskable source needs own and global enable
// - global enable low blocks all maskable
// - top level only for supply drop
// - priority bit one means high level
// - same level ties go to lowest number
// - fixed vector per source
// - enabled supply drop vectors to 0033h
// - supply drop enable bit in watchdog control
// - supply flag set regardless, cleared by software
// - serial port 0 rx or tx, one request
// - serial port 1 rx or tx, one request
// - timer overflow flags cleared on entry
// - ext edge flag clears, level follows pin
`include "irq_unit_defines.vh"

module three_level_interrupt_unit (
	input  wire        clk,
	input  wire        nrst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// sources
	input  wire        supply_low,
	input  wire        ext0_pin_n,
	input  wire        ext1_pin_n,
	input  wire        timer0_overflow,
	input  wire        timer1_overflow,
	input  wire        serial0_rx_flag,
	input  wire        serial0_tx_flag,
	input  wire        serial1_rx_flag,
	input  wire        serial1_tx_flag,
	input  wire        timer2_flag,
	input  wire [3:0]  ext_irq_flag,
	input  wire        can0_irq,
	input  wire        can1_irq,
	input  wire        watchdog_irq_flag,
	input  wire        can_bus_activity_irq,
	// core side
	input  wire        core_ack,
	input  wire        core_reti,
	output reg         irq_req,
	output reg  [7:0]  irq_vector,
	output reg  [3:0]  irq_src,
	output reg  [15:0] src_ack,
	output reg         irq_out
);
	// software registers
	reg  [7:0]  irq_enable_reg_r;      // global + sources 1..7
	reg  [7:0]  irq_priority_reg_r;    // priority, sources 1..7
	reg  [7:0]  ext_irq_enable_reg_r;  // sources 8..15
	reg  [7:0]  ext_irq_priority_reg_r;
	reg         ext0_mode_r;           // 1 = edge triggered
	reg         ext1_mode_r;
	reg         supply_drop_irq_en_r;
	reg  [2:0]  evt_status_r;          // sticky, write one to clear
	reg  [2:0]  evt_mask_r;
	// hardware flags
	reg         supply_drop_flag_r;
	reg         ext0_flag_r;
	reg         ext1_flag_r;
	reg         timer0_overflow_flag_r;
	reg         timer1_overflow_flag_r;
	reg         ext0_prev_n_r;         // for falling edge detect
	reg         ext1_prev_n_r;
	// in-service levels, bit per level
	reg  [2:0]  in_service_r;

	wire        acc;                   // apb access phase
	wire        wr_en;
	wire        rd_en;
	wire [15:0] pend;                  // raw pending per source
	wire [15:0] en;                    // per-source enable
	wire [15:0] hi;                    // per-source high priority
	wire        gen;
	wire [15:0] req_hi;
	wire [15:0] req_lo;
	wire        hi_found;
	wire [3:0]  hi_idx;
	wire        lo_found;
	wire [3:0]  lo_idx;
	reg         cand_ok;
	reg  [3:0]  cand_idx;
	reg  [1:0]  cand_lvl;
	reg  [1:0]  grant_lvl_r;           // level of presented source
	reg  [31:0] rdata_nxt;
	reg         err_nxt;
	wire        entry;                 // core took the grant
	wire [15:0] entry_hot;

	// fixed vector lookup
	function [7:0] vec_of;
		input [3:0] s;
		begin
			case (s)
				4'h0: vec_of = `VEC_SRC0;
				4'h1: vec_of = `VEC_SRC1;
				4'h2: vec_of = `VEC_SRC2;
				4'h3: vec_of = `VEC_SRC3;
				4'h4: vec_of = `VEC_SRC4;
				4'h5: vec_of = `VEC_SRC5;
				4'h6: vec_of = `VEC_SRC6;
				4'h7: vec_of = `VEC_SRC7;
				4'h8: vec_of = `VEC_SRC8;
				4'h9: vec_of = `VEC_SRC9;
				4'ha: vec_of = `VEC_SRC10;
				4'hb: vec_of = `VEC_SRC11;
				4'hc: vec_of = `VEC_SRC12;
				4'hd: vec_of = `VEC_SRC13;
				4'he: vec_of = `VEC_SRC14;
				default: vec_of = `VEC_SRC15;
			endcase
		end
	endfunction

	// one-hot of a source number
	function [15:0] onehot;
		input [3:0] s;
		begin
			onehot = 16'h0001 << s;
		end
	endfunction

	assign acc   = psel & penable;
	// one wait state: pready rises in the second access cycle
	assign wr_en = acc & pready & pwrite;
	assign rd_en = acc & pready & ~pwrite;
	assign entry = core_ack & irq_req;
	assign entry_hot = entry ? onehot(irq_src) : 16'h0000;

	assign pend = {can_bus_activity_irq, watchdog_irq_flag, can1_irq,
		can0_irq, ext_irq_flag, serial1_rx_flag | serial1_tx_flag,
		timer2_flag, serial0_rx_flag | serial0_tx_flag,
		timer1_overflow_flag_r, ext1_flag_r, timer0_overflow_flag_r,
		ext0_flag_r, supply_drop_flag_r};

	assign en = {ext_irq_enable_reg_r[7], ext_irq_enable_reg_r[4],
		ext_irq_enable_reg_r[5], ext_irq_enable_reg_r[6],
		ext_irq_enable_reg_r[3:0], irq_enable_reg_r[6:0],
		supply_drop_irq_en_r};

	assign hi = {ext_irq_priority_reg_r[7], ext_irq_priority_reg_r[4],
		ext_irq_priority_reg_r[5], ext_irq_priority_reg_r[6],
		ext_irq_priority_reg_r[3:0], irq_priority_reg_r[6],
		irq_priority_reg_r[7], irq_priority_reg_r[4:0], 1'b0};

	assign gen = irq_enable_reg_r[`BIT_GLOBAL_EN];

	// source 0 excluded from lower levels
	assign req_hi = {16{gen}} & pend & en & hi & 16'hfffe;
	assign req_lo = {16{gen}} & pend & en & ~hi & 16'hfffe;

	prio_pick #(.n(16)) u_pick_hi (
		.req   (req_hi),
		.found (hi_found),
		.idx   (hi_idx)
	);
	prio_pick #(.n(16)) u_pick_lo (
		.req   (req_lo),
		.found (lo_found),
		.idx   (lo_idx)
	);

	// candidate selection across levels
	always @* begin
		cand_ok  = 1'b0;
		cand_idx = 4'h0;
		cand_lvl = `LVL_LOW;
		if (supply_drop_flag_r & supply_drop_irq_en_r) begin
			cand_idx = 4'h0;
			cand_lvl = `LVL_TOP;
			cand_ok  = ~in_service_r[2];
		end else if (hi_found) begin
			cand_idx = hi_idx;
			cand_lvl = `LVL_HIGH;
			cand_ok  = ~in_service_r[2] & ~in_service_r[1];
		end else if (lo_found) begin
			cand_idx = lo_idx;
			cand_lvl = `LVL_LOW;
			cand_ok  = ~|in_service_r;
		end
	end

	// grant presented to the core, refreshed each cycle
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_req     <= 1'b0;
			irq_vector  <= 8'h00;
			irq_src     <= 4'h0;
			grant_lvl_r <= `LVL_LOW;
			src_ack     <= 16'h0000;
		end else begin
			irq_req     <= cand_ok & ~entry;
			irq_vector  <= vec_of(cand_idx);
			irq_src     <= cand_idx;
			grant_lvl_r <= cand_lvl;
			src_ack     <= entry_hot;
		end
	end

	// in-service tracking; return pops the highest level
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_service_r <= 3'h0;
		end else if (entry) begin
			in_service_r <= in_service_r | (3'h1 << grant_lvl_r);
		end else if (core_reti) begin
			if (in_service_r[2]) begin
				in_service_r[2] <= 1'b0;
			end else if (in_service_r[1]) begin
				in_service_r[1] <= 1'b0;
			end else begin
				in_service_r[0] <= 1'b0;
			end
		end
	end

	// hardware flags; a set beats any clear in the same cycle
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			supply_drop_flag_r     <= 1'b0;
			ext0_flag_r            <= 1'b0;
			ext1_flag_r            <= 1'b0;
			timer0_overflow_flag_r <= 1'b0;
			timer1_overflow_flag_r <= 1'b0;
			ext0_prev_n_r          <= 1'b1;
			ext1_prev_n_r          <= 1'b1;
		end else begin
			ext0_prev_n_r <= ext0_pin_n;
			ext1_prev_n_r <= ext1_pin_n;
			if (supply_low) begin
				supply_drop_flag_r <= 1'b1;
			end else if (wr_en && paddr == `OFS_WATCHDOG_CTRL) begin
				supply_drop_flag_r <= pwdata[`BIT_SUPPLY_FLAG];
			end
			// edge clears on entry, level follows
			if (!ext0_mode_r) begin
				ext0_flag_r <= ~ext0_pin_n;
			end else if (ext0_prev_n_r & ~ext0_pin_n) begin
				ext0_flag_r <= 1'b1;
			end else if (entry_hot[1]) begin
				ext0_flag_r <= 1'b0;
			end else if (wr_en && paddr == `OFS_TIMER_CTRL) begin
				ext0_flag_r <= pwdata[`BIT_EXT0_FLAG];
			end
			if (!ext1_mode_r) begin
				ext1_flag_r <= ~ext1_pin_n;
			end else if (ext1_prev_n_r & ~ext1_pin_n) begin
				ext1_flag_r <= 1'b1;
			end else if (entry_hot[3]) begin
				ext1_flag_r <= 1'b0;
			end else if (wr_en && paddr == `OFS_TIMER_CTRL) begin
				ext1_flag_r <= pwdata[`BIT_EXT1_FLAG];
			end
			if (timer0_overflow) begin
				timer0_overflow_flag_r <= 1'b1;
			end else if (entry_hot[2]) begin
				timer0_overflow_flag_r <= 1'b0;
			end else if (wr_en && paddr == `OFS_TIMER_CTRL) begin
				timer0_overflow_flag_r <= pwdata[`BIT_TIMER0_FLAG];
			end
			if (timer1_overflow) begin
				timer1_overflow_flag_r <= 1'b1;
			end else if (entry_hot[4]) begin
				timer1_overflow_flag_r <= 1'b0;
			end else if (wr_en && paddr == `OFS_TIMER_CTRL) begin
				timer1_overflow_flag_r <= pwdata[`BIT_TIMER1_FLAG];
			end
		end
	end

	// software control registers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_enable_reg_r       <= `RST_BYTE;
			irq_priority_reg_r     <= `RST_BYTE;
			ext_irq_enable_reg_r   <= `RST_BYTE;
			ext_irq_priority_reg_r <= `RST_BYTE;
			ext0_mode_r            <= 1'b0;
			ext1_mode_r            <= 1'b0;
			supply_drop_irq_en_r   <= 1'b0;
			evt_mask_r             <= `RST_EVT;
		end else if (wr_en) begin
			if (paddr == `OFS_IRQ_ENABLE) begin
				irq_enable_reg_r <= pwdata[7:0];
			end else if (paddr == `OFS_IRQ_PRIORITY) begin
				irq_priority_reg_r <= pwdata[7:0];
			end else if (paddr == `OFS_EXT_ENABLE) begin
				ext_irq_enable_reg_r <= pwdata[7:0];
			end else if (paddr == `OFS_EXT_PRIORITY) begin
				ext_irq_priority_reg_r <= pwdata[7:0];
			end else if (paddr == `OFS_TIMER_CTRL) begin
				ext0_mode_r <= pwdata[`BIT_EXT0_MODE];
				ext1_mode_r <= pwdata[`BIT_EXT1_MODE];
			end else if (paddr == `OFS_WATCHDOG_CTRL) begin
				supply_drop_irq_en_r <= pwdata[`BIT_SUPPLY_EN];
			end else if (paddr == `OFS_EVT_MASK) begin
				evt_mask_r <= pwdata[`EVT_WIDTH-1:0];
			end
		end
	end

	// sticky events and the masked interrupt line
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			evt_status_r <= `RST_EVT;
			irq_out      <= 1'b0;
		end else begin
			// new events win over a write-one clear
			evt_status_r <= (evt_status_r &
				~((wr_en && paddr == `OFS_EVT_STATUS) ?
				pwdata[`EVT_WIDTH-1:0] : `RST_EVT)) |
				{entry & |in_service_r, entry,
				supply_low & ~supply_drop_flag_r};
			irq_out <= |(evt_status_r & evt_mask_r);
		end
	end

	// read mux; unmapped reads zero with an error
	always @* begin
		rdata_nxt = 32'h0000_0000;
		err_nxt   = 1'b0;
		if (paddr == `OFS_IRQ_ENABLE) begin
			rdata_nxt[7:0] = irq_enable_reg_r;
		end else if (paddr == `OFS_IRQ_PRIORITY) begin
			rdata_nxt[7:0] = irq_priority_reg_r;
		end else if (paddr == `OFS_EXT_ENABLE) begin
			rdata_nxt[7:0] = ext_irq_enable_reg_r;
		end else if (paddr == `OFS_EXT_PRIORITY) begin
			rdata_nxt[7:0] = ext_irq_priority_reg_r;
		end else if (paddr == `OFS_TIMER_CTRL) begin
			rdata_nxt[7:0] = {timer1_overflow_flag_r, 1'b0,
				timer0_overflow_flag_r, 1'b0, ext1_flag_r, ext1_mode_r,
				ext0_flag_r, ext0_mode_r};
		end else if (paddr == `OFS_WATCHDOG_CTRL) begin
			rdata_nxt[`BIT_SUPPLY_EN]   = supply_drop_irq_en_r;
			rdata_nxt[`BIT_SUPPLY_FLAG] = supply_drop_flag_r;
		end else if (paddr == `OFS_EVT_STATUS) begin
			rdata_nxt[`EVT_WIDTH-1:0] = evt_status_r;
		end else if (paddr == `OFS_EVT_MASK) begin
			rdata_nxt[`EVT_WIDTH-1:0] = evt_mask_r;
		end else if (paddr == `OFS_SVC_STATE) begin
			rdata_nxt[15:0] = pend;
			rdata_nxt[18:16] = in_service_r;
			rdata_nxt[23:20] = irq_src;
			rdata_nxt[24] = irq_req;
		end else begin
			err_nxt = 1'b1;
		end
	end

	// apb handshake, one wait state keeps outputs registered
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc & ~pready;
			pslverr <= acc & ~pready & err_nxt;
			if (acc & ~pready & ~pwrite) begin
				prdata <= rdata_nxt;
			end
		end
	end
endmodule

// file: hdl/irq_unit_defines.vh
// register offsets, bit positions, vectors and reset values for the
// three level interrupt unit; definitions only, included by bare name
`ifndef IRQ_UNIT_DEFINES_VH
`define IRQ_UNIT_DEFINES_VH

// apb byte offsets, one aligned word each
`define OFS_IRQ_ENABLE      12'h000
`define OFS_IRQ_PRIORITY    12'h004
`define OFS_EXT_ENABLE      12'h008
`define OFS_EXT_PRIORITY    12'h00c
`define OFS_TIMER_CTRL      12'h010
`define OFS_WATCHDOG_CTRL   12'h014
`define OFS_EVT_STATUS      12'h018
`define OFS_EVT_MASK        12'h01c
`define OFS_SVC_STATE       12'h020

// irq_enable_reg
`define BIT_GLOBAL_EN       7
// timer_ctrl_reg
`define BIT_EXT0_MODE       0
`define BIT_EXT0_FLAG       1
`define BIT_EXT1_MODE       2
`define BIT_EXT1_FLAG       3
`define BIT_TIMER0_FLAG     5
`define BIT_TIMER1_FLAG     7
// watchdog_ctrl_reg
`define BIT_SUPPLY_FLAG     4
`define BIT_SUPPLY_EN       5
// event status / mask
`define EVT_SUPPLY_DROP     0
`define EVT_SVC_ENTRY       1
`define EVT_NESTED          2
`define EVT_WIDTH           3

// reset values
`define RST_BYTE            8'h00
`define RST_EVT             3'h0

// priority levels
`define LVL_LOW             2'h0
`define LVL_HIGH            2'h1
`define LVL_TOP             2'h2

// fixed vectors by natural priority
`define VEC_SRC0            8'h33
`define VEC_SRC1            8'h03
`define VEC_SRC2            8'h0b
`define VEC_SRC3            8'h13
`define VEC_SRC4            8'h1b
`define VEC_SRC5            8'h23
`define VEC_SRC6            8'h2b
`define VEC_SRC7            8'h3b
`define VEC_SRC8            8'h43
`define VEC_SRC9            8'h4b
`define VEC_SRC10           8'h53
`define VEC_SRC11           8'h5b
`define VEC_SRC12           8'h6b
`define VEC_SRC13           8'h73
`define VEC_SRC14           8'h63
`define VEC_SRC15           8'h7b

`endif

// file: hdl/prio_pick.v
// lowest-index picker over a request vector
// assumes the caller registers the result where it leaves the block
module prio_pick #(
	parameter n = 16
) (
	input  wire [n-1:0] req,
	output reg          found,
	output reg  [3:0]   idx
);
	integer i;

	// scan from the top so the lowest index is the last to win
	always @* begin
		found = 1'b0;
		idx   = 4'h0;
		for (i = n - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				found = 1'b1;
				idx   = i[3:0];
			end
		end
	end
endmodule

// file: bench/irq_unit_assertions.sv
// port checks for the three level interrupt unit
// assumes a bind into the unit, one clock domain
module irq_unit_assertions (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        core_ack,
	input wire logic        irq_req,
	input wire logic [7:0]  irq_vector,
	input wire logic [3:0]  irq_src,
	input wire logic [15:0] src_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// fixed vector table by source number
	localparam logic [7:0] vt [16] = '{8'h33, 8'h03, 8'h0b, 8'h13,
		8'h1b, 8'h23, 8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b,
		8'h6b, 8'h73, 8'h63, 8'h7b};
	// core takes the presented grant
	sequence s_take;
		irq_req && core_ack;
	endsequence
	// apb setup then first access cycle
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	a_ack_onehot: assert property ($onehot0(src_ack))
		else $error("entry ack not one-hot");
	a_ack_source: assert property (s_take |=>
		src_ack == (16'h1 << $past(irq_src)))
		else $error("entry ack for wrong source");
	a_no_stray: assert property (!(irq_req && core_ack) |=>
		src_ack == 16'h0)
		else $error("entry ack without a taken grant");
	a_ack_single: assert property (src_ack != 16'h0 |=>
		src_ack == 16'h0)
		else $error("entry ack longer than a cycle");
	a_req_drops: assert property (s_take |=> !irq_req)
		else $error("grant still shown after entry");
	a_vector_map: assert property (irq_req |->
		irq_vector == vt[irq_src])
		else $error("vector does not match source");
	a_apb_wait: assert property (s_access |-> !pready ##1 pready)
		else $error("apb answer not after one wait");
	a_ready_once: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("slave error without ready");
endmodule

// file: bench/core_model.sv
// processor core stand-in: takes grants, enters and leaves routines
// assumes the unit's grant outputs are registered on clk
module core_model (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic [3:0] ack_dly,
	input wire logic       ret_en,
	output logic           core_ack,
	output logic           core_reti,
	output logic [7:0]     taken_vec
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_c;  // cycles the grant has been shown
	int run_c;   // cycles since last entry or return
	int depth;   // routines entered, not yet left
	// ack after a chosen delay; return only while allowed
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_ack <= 1'b0;
			core_reti <= 1'b0;
			taken_vec <= 8'h00;
			wait_c <= 0;
			run_c <= 0;
			depth <= 0;
		end else begin
			core_ack <= 1'b0;
			core_reti <= 1'b0;
			wait_c <= irq_req ? wait_c + 1 : 0;
			run_c <= run_c + 1;
			// entry counted only when the unit saw a grant
			if (core_ack && irq_req) begin
				taken_vec <= irq_vector;
				depth <= depth + 1;
				run_c <= 0;
			end else if (core_reti) begin
				depth <= depth - 1;
			end
			// never ack and return in one cycle: return would be lost
			if (irq_req && !core_ack && wait_c >= ack_dly) begin
				core_ack <= 1'b1;
			end else if (ret_en && depth > 0 && run_c > 5
				&& !core_reti && !core_ack) begin
				core_reti <= 1'b1;
				run_c <= 0;
			end
		end
	end
endmodule

// file: bench/three_level_interrupt_unit_test.sv
// self-checking bench for the three level interrupt unit
// assumes the defines header is on the include path
`include "irq_unit_defines.vh"
module three_level_interrupt_unit_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic        pready, pslverr, ev;
	logic        supply_low = 1'b0;
	logic        rxsel = 1'b0;   // serial rx or tx flag used
	logic        ret_en = 1'b1;  // core may leave routines
	logic [3:0]  ack_dly = 4'h0;
	logic [15:0] src = 16'h0;    // source lines by number
	logic [15:0] keep = 16'h0;   // lines left up after entry
	logic [15:0] src_ack;
	logic        core_ack, core_reti, irq_req, irq_out;
	logic [7:0]  irq_vector, taken_vec;
	logic [3:0]  irq_src;
	logic [23:0] exp_g;
	logic [23:0] expq [$];       // expected one-hot ack and vector
	int          errors = 0;
	int          cmp_count = 0;
	localparam logic [7:0] vt [16] = '{8'h33, 8'h03, 8'h0b, 8'h13,
		8'h1b, 8'h23, 8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b,
		8'h6b, 8'h73, 8'h63, 8'h7b};
	always #4 clk = ~clk;
	three_level_interrupt_unit uut (.clk, .nrst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.supply_low, .ext0_pin_n(~src[1]), .ext1_pin_n(~src[3]),
		.timer0_overflow(src[2]), .timer1_overflow(src[4]),
		.serial0_rx_flag(src[5] & rxsel),
		.serial0_tx_flag(src[5] & ~rxsel),
		.serial1_rx_flag(src[7] & rxsel),
		.serial1_tx_flag(src[7] & ~rxsel), .timer2_flag(src[6]),
		.ext_irq_flag(src[11:8]), .can0_irq(src[12]),
		.can1_irq(src[13]), .watchdog_irq_flag(src[14]),
		.can_bus_activity_irq(src[15]), .core_ack, .core_reti,
		.irq_req, .irq_vector, .irq_src, .src_ack, .irq_out);
	core_model core (.clk, .nrst, .irq_req, .irq_vector, .ack_dly,
		.ret_en, .core_ack, .core_reti, .taken_vec);
	task automatic results();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", what, e, g);
		end
	endtask
	// a used-up wait is a mismatch and ends the run
	task automatic hang();
		chk("wait", 32'h0, 32'h1);
		results();
	endtask
	// one apb transfer, idle cycle after so psel never flips twice
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20)
			hang();
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rv, ev);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, rv, ev);
		chk("read", x, rv);
	endtask
	function automatic logic [23:0] ex(input int s);
		return {16'h1 << s, vt[s]};
	endfunction
	// timer 0 and timer 1 lines are one-cycle pulses
	task automatic raise(input logic [15:0] m);
		src <= src | m;
		@(posedge clk);
		src <= src & ~16'h0014;
	endtask
	task automatic quiet();
		repeat (20) @(posedge clk);
	endtask
	task automatic drain();
		for (int k = 0; k < 300 && expq.size() > 0; k++)
			@(posedge clk);
		// one more edge so the monitor's source clear lands first
		@(posedge clk);
		if (expq.size() > 0)
			hang();
	endtask
	// each entry ack checked against the oldest note
	always @(posedge clk) begin
		if (nrst && src_ack !== 16'h0) begin
			exp_g = expq.size() ? expq.pop_front() : 24'h0;
			chk("grant", exp_g, {src_ack, taken_vec});
			src <= src & ~(src_ack & ~keep);
		end
	end
	initial begin
		void'($urandom(57));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// all slots zero after reset, unmapped slot refused
		for (int a = 0; a < 36; a += 4)
			rd(a[11:0], 32'h0);
		apb(1'b0, 12'h024, 32'h0, rv, ev);
		chk("slverr", 32'h1, ev);
		// global enable low blocks a maskable source
		wr(`OFS_IRQ_ENABLE, 32'h7f);
		wr(`OFS_EXT_ENABLE, 32'hff);
		raise(16'h0002);
		quiet();
		chk("req", 32'h0, irq_req);
		expq.push_back(ex(1));
		wr(`OFS_IRQ_ENABLE, 32'hff);
		drain();
		// own enable low blocks with global enable high
		wr(`OFS_IRQ_ENABLE, 32'h80);
		raise(16'h0008);
		quiet();
		chk("req", 32'h0, irq_req);
		expq.push_back(ex(3));
		wr(`OFS_IRQ_ENABLE, 32'hff);
		drain();
		// sources 1 to 15 each alone, random core delay and serial flag
		for (int s = 1; s < 16; s++) begin
			ack_dly <= 4'($urandom % 6);
			rxsel <= 1'($urandom);
			expq.push_back(ex(s));
			raise(16'h1 << s);
			drain();
		end
		quiet();
		rd(`OFS_TIMER_CTRL, 32'h0);
		// edge flag clears on entry though pin stays low
		keep <= 16'h0002;
		wr(`OFS_TIMER_CTRL, 32'h1);
		expq.push_back(ex(1));
		raise(16'h0002);
		drain();
		quiet();
		rd(`OFS_TIMER_CTRL, 32'h1);
		// level flag follows the pin
		wr(`OFS_IRQ_ENABLE, 32'hfe);
		wr(`OFS_TIMER_CTRL, 32'h0);
		rd(`OFS_TIMER_CTRL, 32'h2);
		src[1] <= 1'b0;
		keep <= 16'h0;
		quiet();
		rd(`OFS_TIMER_CTRL, 32'h0);
		wr(`OFS_IRQ_ENABLE, 32'hff);
		// same level waits, higher level nests
		ret_en <= 1'b0;
		expq.push_back(ex(3));
		raise(16'h0008);
		drain();
		raise(16'h0200);
		quiet();
		chk("req", 32'h0, irq_req);
		expq.push_back(ex(9));
		wr(`OFS_EXT_PRIORITY, 32'h2);
		drain();
		ret_en <= 1'b1;
		// level outranks natural order, then ties by number
		expq.push_back(ex(9));
		expq.push_back(ex(3));
		raise(16'h0208);
		drain();
		wr(`OFS_EXT_PRIORITY, 32'h0);
		expq.push_back(ex(3));
		expq.push_back(ex(9));
		raise(16'h0208);
		drain();
		// timer 2 priority sits on bit 7 and nests over serial 0
		quiet();
		ret_en <= 1'b0;
		expq.push_back(ex(5));
		raise(16'h0020);
		drain();
		wr(`OFS_IRQ_PRIORITY, 32'h80);
		expq.push_back(ex(6));
		raise(16'h0040);
		drain();
		// low and high levels in service, nothing pending
		rd(`OFS_SVC_STATE, 32'h0003_0000);
		wr(`OFS_IRQ_PRIORITY, 32'h0);
		ret_en <= 1'b1;
		// disabled supply drop only sets its sticky flag
		wr(`OFS_IRQ_ENABLE, 32'h0);
		supply_low <= 1'b1;
		quiet();
		supply_low <= 1'b0;
		quiet();
		rd(`OFS_WATCHDOG_CTRL, 32'h10);
		wr(`OFS_WATCHDOG_CTRL, 32'h0);
		rd(`OFS_WATCHDOG_CTRL, 32'h0);
		// enabled supply drop ignores global enable
		ret_en <= 1'b0;
		wr(`OFS_WATCHDOG_CTRL, 32'h20);
		expq.push_back(ex(0));
		supply_low <= 1'b1;
		drain();
		supply_low <= 1'b0;
		wr(`OFS_WATCHDOG_CTRL, 32'h20);
		ret_en <= 1'b1;
		quiet();
		// event interrupt: masked, raised, cleared
		chk("irq_out", 32'h0, irq_out);
		wr(`OFS_EVT_MASK, 32'h2);
		quiet();
		chk("irq_out", 32'h1, irq_out);
		wr(`OFS_EVT_STATUS, 32'h7);
		quiet();
		chk("irq_out", 32'h0, irq_out);
		rd(`OFS_EVT_STATUS, 32'h0);
		results();
	end
endmodule
bind three_level_interrupt_unit irq_unit_assertions chk (.clk,
	.nrst, .psel, .penable, .pready, .pslverr, .core_ack, .irq_req,
	.irq_vector, .irq_src, .src_ack);
